// ==== verilog/sfcfe_pkg.sv ====
// Constants and types shared by both ends of the serial flash command front end, and the opcode decoder of the device end.
// Assumes SPI modes 0 and 3 only and a single data lane on the link.
// Operation
// - host opens frame with select, then opcode
// - every byte travels most significant bit first
// - select release ends the current operation
// - unknown opcode ignored until next frame
// - truncated header performs nothing, back idle
// - address commands carry three address bytes
// - top five address bits are ignored
// - 0Bh and 03h start sequential array reads
// - fast read needs one dummy byte
// - read address counter advances automatically
// - after header, data shifts out per clock
// - wrap from top to zero, no delay
// - select release ends read, output floats
// - mid-byte select release accepted cleanly
// - FFFFh dual reset, FFh quad reset
// - block erase with address, chip erase without
// - 02h program: address then data bytes
// - 06h, 04h, 50h are opcode-only commands
// - security erase, program, read with address
// - status read one byte, write one/two
// - 9Fh three ID bytes, 90h two
// - B9h power-down, ABh resume, optional ID
// - sample on rising, drive on falling edge
package sfcfe_pkg;

  // Opcodes
  localparam logic [7:0] OP_READ_FAST  = 8'h0B;
  localparam logic [7:0] OP_READ_SLOW  = 8'h03;
  localparam logic [7:0] OP_READ_DO    = 8'h3B;
  localparam logic [7:0] OP_READ_DIO   = 8'hBB;
  localparam logic [7:0] OP_READ_QO    = 8'h6B;
  localparam logic [7:0] OP_READ_QIO   = 8'hEB;
  localparam logic [7:0] OP_CRM_RESET  = 8'hFF;
  localparam logic [7:0] OP_ERASE_4K   = 8'h20;
  localparam logic [7:0] OP_ERASE_32K  = 8'h52;
  localparam logic [7:0] OP_ERASE_64K  = 8'hD8;
  localparam logic [7:0] OP_CHIP_ER_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ER_B  = 8'hC7;
  localparam logic [7:0] OP_PROGRAM    = 8'h02;
  localparam logic [7:0] OP_WR_EN      = 8'h06;
  localparam logic [7:0] OP_WR_DIS     = 8'h04;
  localparam logic [7:0] OP_WR_EN_VOL  = 8'h50;
  localparam logic [7:0] OP_SEC_ERASE  = 8'h44;
  localparam logic [7:0] OP_SEC_PROG   = 8'h42;
  localparam logic [7:0] OP_SEC_READ   = 8'h48;
  localparam logic [7:0] OP_STAT_RD1   = 8'h05;
  localparam logic [7:0] OP_STAT_RD2   = 8'h35;
  localparam logic [7:0] OP_STAT_WR    = 8'h01;
  localparam logic [7:0] OP_JEDEC_ID   = 8'h9F;
  localparam logic [7:0] OP_READ_ID    = 8'h90;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_RESUME     = 8'hAB;

  // Frame layout and counts
  localparam logic [1:0] ADR_BYTES    = 2'h3;
  localparam logic [1:0] DUM_ONE      = 2'h1;
  localparam logic [1:0] DUM_RESUME   = 2'h3;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [8:0] CNT_MAX      = 9'h100;
  localparam int         ARRAY_AW     = 19;
  localparam logic [3:0] HOST_HALF    = 4'h3;
  localparam logic [3:0] HOST_GAP     = 4'h8;

  typedef enum logic [1:0] {DIR_NONE, DIR_IN, DIR_OUT} sfcfe_dir_t;

  typedef struct packed {
    logic       sup;
    logic [1:0] nadr;
    logic [1:0] ndum;
    sfcfe_dir_t dir;
  } sfcfe_dec_t;

  typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DUM, ST_IN, ST_OUT, ST_IGN} sfcfe_dst_t;
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_END, H_GAP} sfcfe_hst_t;

  // Frame shape of each supported opcode
  function automatic sfcfe_dec_t sfcfe_decode(input logic [7:0] op);
    sfcfe_dec_t d;
    d = '{sup: 1'b1, nadr: 2'h0, ndum: 2'h0, dir: DIR_NONE};
    case (op)
      OP_READ_FAST, OP_SEC_READ:            d = '{1'b1, ADR_BYTES, DUM_ONE, DIR_OUT};
      OP_READ_SLOW:                         d = '{1'b1, ADR_BYTES, 2'h0, DIR_OUT};
      OP_READ_DO, OP_READ_DIO,
      OP_READ_QO, OP_READ_QIO:              d = '{1'b1, ADR_BYTES, 2'h0, DIR_NONE};
      OP_ERASE_4K, OP_ERASE_32K,
      OP_ERASE_64K, OP_SEC_ERASE:           d = '{1'b1, ADR_BYTES, 2'h0, DIR_NONE};
      OP_PROGRAM, OP_SEC_PROG:              d = '{1'b1, ADR_BYTES, 2'h0, DIR_IN};
      OP_READ_ID:                           d = '{1'b1, ADR_BYTES, 2'h0, DIR_OUT};
      OP_STAT_RD1, OP_STAT_RD2, OP_JEDEC_ID: d = '{1'b1, 2'h0, 2'h0, DIR_OUT};
      OP_RESUME:                            d = '{1'b1, 2'h0, DUM_RESUME, DIR_OUT};
      OP_STAT_WR, OP_CRM_RESET:             d = '{1'b1, 2'h0, 2'h0, DIR_IN};
      OP_CHIP_ER_A, OP_CHIP_ER_B, OP_WR_EN,
      OP_WR_DIS, OP_WR_EN_VOL, OP_POWER_DOWN: d = '{1'b1, 2'h0, 2'h0, DIR_NONE};
      default:                              d.sup = 1'b0;
    endcase
    return d;
  endfunction

endpackage

// ==== verilog/sfcfe_spi_if.sv ====
// Single-lane SPI link between the flash command front end and its host.
// Assumes the bench instantiates it once and connects both modports.
`timescale 1ns/100ps
interface sfcfe_spi_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  wire  so_line;

  // Released line shows the inverse of the last bit, so a sample taken too early shows up
  assign so_line = so_oe ? so : ~so;

  modport dev (input cs_n, input sck, input si, output so, output so_oe);
  modport host (output cs_n, output sck, output si, input so_line);
endinterface

// ==== verilog/sfcfe_host.sv ====
// Host end: SPI master that frames one command per start request.
// Assumes core_clk_i well above the link rate; the link clock is divided from it.
`timescale 1ns/100ps
module sfcfe_host #(
  parameter logic [3:0] HALF = sfcfe_pkg::HOST_HALF
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        mode3_i,
  input  wire logic        start_i,
  input  wire logic [7:0]  op_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [2:0]  n_hdr_i,
  input  wire logic [8:0]  n_data_i,
  input  wire logic [7:0]  wr_data_i,
  output logic             busy_o,
  output logic             wr_take_o,
  output logic             rd_valid_o,
  output logic [7:0]       rd_data_o,
  sfcfe_spi_if.host        spi
);
  sfcfe_pkg::sfcfe_hst_t state_r;
  logic        cs_n_r, sck_r, si_r, first_r, mode3_r;
  logic        so_s1_r, so_s2_r;
  logic [3:0]  div_r;
  logic [2:0]  bit_r;
  logic [9:0]  byte_r, last_r;
  logic [7:0]  sh_r, rx_r, nb;
  logic [2:0]  n_hdr_r;
  logic [23:0] addr_r;
  logic        tick, nb_data;
  logic [9:0]  nidx;

  assign spi.cs_n = cs_n_r;
  assign spi.sck  = sck_r;
  assign spi.si   = si_r;
  assign tick     = div_r == ((state_r == sfcfe_pkg::H_GAP) ? sfcfe_pkg::HOST_GAP : HALF) - 4'h1;

  // Serial input from the device is a pin: two flops first
  always_ff @(posedge core_clk_i) begin
    so_s1_r <= spi.so_line;
    so_s2_r <= so_s1_r;
  end

  // Next byte to send: address, then zero dummies, then user data
  always_comb begin
    nidx    = byte_r + 10'h001;
    nb_data = nidx > {7'h00, n_hdr_r};
    case (nidx[2:0])
      3'h1:    nb = addr_r[23:16];
      3'h2:    nb = addr_r[15:8];
      3'h3:    nb = addr_r[7:0];
      default: nb = 8'h00;
    endcase
    if (nb_data) begin
      nb = wr_data_i;
    end
  end

  // Frame sequencer; data changes on falling, samples on rising
  always_ff @(posedge core_clk_i) begin
    wr_take_o  <= 1'b0;
    rd_valid_o <= 1'b0;
    if (rst_i) begin
      state_r <= sfcfe_pkg::H_IDLE;
      busy_o  <= 1'b0;
      cs_n_r  <= 1'b1;
      sck_r   <= 1'b0;
      si_r    <= 1'b0;
      div_r   <= 4'h0;
      bit_r   <= 3'h0;
      byte_r  <= 10'h000;
      last_r  <= 10'h000;
      sh_r    <= 8'h00;
      rx_r    <= 8'h00;
      first_r <= 1'b0;
      mode3_r <= 1'b0;
      n_hdr_r <= 3'h0;
      addr_r  <= 24'h000000;
      rd_data_o <= 8'h00;
    end else begin
      div_r <= tick ? 4'h0 : div_r + 4'h1;
      case (state_r)
        sfcfe_pkg::H_IDLE: begin
          div_r <= 4'h0;
          sck_r <= mode3_i;
          if (start_i) begin
            state_r <= sfcfe_pkg::H_SHIFT;
            busy_o  <= 1'b1;
            cs_n_r  <= 1'b0;
            sh_r    <= op_i;
            si_r    <= op_i[7];
            bit_r   <= 3'h0;
            byte_r  <= 10'h000;
            last_r  <= {7'h00, n_hdr_i} + {1'b0, n_data_i};
            first_r <= mode3_i;
            mode3_r <= mode3_i;
            n_hdr_r <= n_hdr_i;
            addr_r  <= addr_i;
          end
        end
        sfcfe_pkg::H_SHIFT: if (tick) begin
          if (!sck_r) begin
            sck_r <= 1'b1;
            rx_r  <= {rx_r[6:0], so_s2_r};
            if (bit_r == sfcfe_pkg::BIT_LAST && byte_r > {7'h00, n_hdr_r}) begin
              rd_valid_o <= 1'b1;
              rd_data_o  <= {rx_r[6:0], so_s2_r};
            end
            if (bit_r == sfcfe_pkg::BIT_LAST && byte_r == last_r) begin
              state_r <= sfcfe_pkg::H_END;
            end
          end else begin
            sck_r <= 1'b0;
            if (first_r) begin
              first_r <= 1'b0;                           // Mode 3 leading edge carries nothing
            end else if (bit_r == sfcfe_pkg::BIT_LAST) begin
              bit_r     <= 3'h0;
              byte_r    <= nidx;
              sh_r      <= nb;
              si_r      <= nb[7];
              wr_take_o <= nb_data;
            end else begin
              bit_r <= bit_r + 3'h1;
              sh_r  <= {sh_r[6:0], 1'b0};
              si_r  <= sh_r[6];
            end
          end
        end
        sfcfe_pkg::H_END: if (tick) begin
          sck_r   <= mode3_r;
          cs_n_r  <= 1'b1;
          state_r <= sfcfe_pkg::H_GAP;
        end
        default: if (tick) begin
          state_r <= sfcfe_pkg::H_IDLE;
          busy_o  <= 1'b0;                                // Busy until the select gap is over
        end
      endcase
    end
  end
endmodule

// ==== verilog/sfcfe_dev.sv ====
// Device end: serial flash command front end clocked by the link clock.
// Assumes the host keeps select high at least four core clocks between frames.
`timescale 1ns/100ps
module sfcfe_dev #(
  parameter int         MEM_AW  = 8,
  parameter logic [7:0] STAT1   = 8'h00,
  parameter logic [7:0] STAT2   = 8'h00,
  parameter logic [7:0] MFR_ID  = 8'h5A,  // Arbitrary value
  parameter logic [7:0] DEV_ID  = 8'h11,  // Arbitrary value
  parameter logic [7:0] DEV_ID2 = 8'h22   // Arbitrary value
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  sfcfe_spi_if.dev         spi,
  output logic             cmd_valid_o,
  output logic [7:0]       cmd_op_o,
  output logic [18:0]      cmd_addr_o,
  output logic [8:0]       cmd_cnt_o,
  output logic             cmd_dual_o
);
  // Link-side state
  sfcfe_pkg::sfcfe_dst_t state_r, dir_state;
  sfcfe_pkg::sfcfe_dec_t dec;
  logic [2:0]  bit_cnt_r;
  logic [7:0]  sh_r;
  logic [1:0]  hb_r;
  logic [7:0]  op_r;
  logic [18:0] addr_r;
  logic [8:0]  cnt_r;
  logic        dual_r;
  logic        hdr_ok_r;
  logic [7:0]  obyte_r;
  logic [7:0]  ob_r;
  logic        so_r;
  logic        so_oe_r;
  logic [7:0]  mem [0:(2**MEM_AW)-1];

  // Combinational helpers
  logic [7:0]  byte_in;
  logic        last_bit;
  logic [7:0]  op_now;
  logic [18:0] addr_now;
  logic        hdr_done;
  logic        dum_done;
  logic [7:0]  first_out;
  logic [7:0]  next_out;

  // Core-side crossing
  logic        cs_s1_r, cs_s2_r, cs_s3_r;
  logic        ok_s1_r, ok_s2_r;

  assign spi.so    = so_r;
  assign spi.so_oe = so_oe_r;

  // Byte assembly, msb first on rising edges
  assign byte_in  = {sh_r[6:0], spi.si};
  assign last_bit = bit_cnt_r == sfcfe_pkg::BIT_LAST;
  assign op_now   = (state_r == sfcfe_pkg::ST_OPC) ? byte_in : op_r;
  assign dec      = sfcfe_pkg::sfcfe_decode(op_now);

  // Only 19 address bits are kept; the upper five fall off
  assign addr_now = (state_r == sfcfe_pkg::ST_ADDR) ? {addr_r[10:0], byte_in} : addr_r;

  // Header is opcode plus address bytes; truncation leaves it unset
  always_comb begin
    hdr_done = 1'b0;
    if (last_bit && dec.sup) begin
      if (state_r == sfcfe_pkg::ST_OPC) begin
        hdr_done = dec.nadr == 2'h0;
      end else if (state_r == sfcfe_pkg::ST_ADDR) begin
        hdr_done = hb_r == sfcfe_pkg::ADR_BYTES - 2'h1;
      end
    end
  end

  assign dum_done = (state_r == sfcfe_pkg::ST_DUM) && last_bit && (hb_r == dec.ndum - 2'h1);

  // Phase that follows header and dummies
  always_comb begin
    case (dec.dir)
      sfcfe_pkg::DIR_OUT: dir_state = sfcfe_pkg::ST_OUT;
      sfcfe_pkg::DIR_IN:  dir_state = sfcfe_pkg::ST_IN;
      default:            dir_state = sfcfe_pkg::ST_IGN;
    endcase
  end

  // Answer byte for a given output index
  function automatic logic [7:0] answer(input logic [7:0] op, input logic [7:0] idx, input logic [18:0] a);
    logic [7:0] r;
    r = mem[a[MEM_AW-1:0]];
    case (op)
      sfcfe_pkg::OP_STAT_RD1: r = STAT1;
      sfcfe_pkg::OP_STAT_RD2: r = STAT2;
      sfcfe_pkg::OP_JEDEC_ID: r = (idx == 8'h00) ? MFR_ID : (idx == 8'h01) ? DEV_ID : DEV_ID2;
      sfcfe_pkg::OP_READ_ID:  r = idx[0] ? DEV_ID : MFR_ID;
      sfcfe_pkg::OP_RESUME:   r = DEV_ID;
      default:                r = mem[a[MEM_AW-1:0]];
    endcase
    return r;
  endfunction

  assign first_out = answer(op_now, 8'h00, addr_now);
  assign next_out  = answer(op_r, ob_r + 8'h01, addr_r + 19'h00001);

  // Frame state; select high clears it at once
  always_ff @(posedge spi.sck or posedge spi.cs_n) begin
    if (spi.cs_n) begin
      state_r   <= sfcfe_pkg::ST_OPC;
      bit_cnt_r <= 3'h0;
      hb_r      <= 2'h0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      case (state_r)
        sfcfe_pkg::ST_OPC: if (last_bit) begin
          if (!dec.sup) begin
            state_r <= sfcfe_pkg::ST_IGN;
          end else if (dec.nadr != 2'h0) begin
            state_r <= sfcfe_pkg::ST_ADDR;
          end else if (dec.ndum != 2'h0) begin
            state_r <= sfcfe_pkg::ST_DUM;
          end else begin
            state_r <= dir_state;
          end
        end
        sfcfe_pkg::ST_ADDR: if (last_bit) begin
          hb_r <= hb_r + 2'h1;
          if (hdr_done) begin
            hb_r    <= 2'h0;
            state_r <= (dec.ndum != 2'h0) ? sfcfe_pkg::ST_DUM : dir_state;
          end
        end
        sfcfe_pkg::ST_DUM: if (last_bit) begin
          hb_r <= hb_r + 2'h1;
          if (dum_done) begin
            state_r <= dir_state;
          end
        end
        default: begin
          // Input and output phases run until select rises; ignore holds too
        end
      endcase
    end
  end

  // Shift register and frame capture; not reset by select so the core can read them
  always_ff @(posedge spi.sck) begin
    sh_r <= byte_in;
    if (state_r == sfcfe_pkg::ST_OPC && last_bit) begin
      op_r <= byte_in;
    end
    if (hdr_done) begin
      cnt_r  <= 9'h000;
      dual_r <= 1'b0;
    end
    if ((state_r == sfcfe_pkg::ST_ADDR) && last_bit) begin
      addr_r <= addr_now;
    end
    // Data bytes after header: count, program, detect dual reset
    if (state_r == sfcfe_pkg::ST_IN && last_bit) begin
      if (cnt_r != sfcfe_pkg::CNT_MAX) begin
        cnt_r <= cnt_r + 9'h001;
      end
      if (op_r == sfcfe_pkg::OP_CRM_RESET && cnt_r == 9'h000 && byte_in == sfcfe_pkg::OP_CRM_RESET) begin
        dual_r <= 1'b1;
      end
      if (op_r == sfcfe_pkg::OP_PROGRAM) begin
        mem[addr_r[MEM_AW-1:0]] <= byte_in;
        addr_r <= {addr_r[18:8], addr_r[7:0] + 8'h01};  // Page program wraps inside its page
      end
    end
    // Output byte staging; 19-bit counter wraps 07FFFFh to zero
    if ((hdr_done || dum_done) && dir_state == sfcfe_pkg::ST_OUT && dec.ndum == 2'h0 && state_r != sfcfe_pkg::ST_DUM) begin
      obyte_r <= first_out;
      ob_r    <= 8'h00;
    end else if (dum_done && dir_state == sfcfe_pkg::ST_OUT) begin
      obyte_r <= first_out;
      ob_r    <= 8'h00;
    end else if (state_r == sfcfe_pkg::ST_OUT && last_bit) begin
      obyte_r <= next_out;
      ob_r    <= ob_r + 8'h01;
      addr_r  <= addr_r + 19'h00001;
    end
  end

  // Header complete flag; cleared at the first clock of each new frame
  // Reset here is asynchronous because the link clock may not run during core reset
  always_ff @(posedge spi.sck or posedge rst_i) begin
    if (rst_i) begin
      hdr_ok_r <= 1'b0;
    end else if (state_r == sfcfe_pkg::ST_OPC && bit_cnt_r == 3'h0) begin
      hdr_ok_r <= 1'b0;
    end else if (hdr_done) begin
      hdr_ok_r <= 1'b1;
    end
  end

  // Output driven on falling edges, msb first; floats once select rises
  always_ff @(negedge spi.sck or posedge spi.cs_n) begin
    if (spi.cs_n) begin
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      so_oe_r <= state_r == sfcfe_pkg::ST_OUT;
      so_r    <= obyte_r[~bit_cnt_r];
    end
  end

  // Select and header flag reach the core through two flops each
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      ok_s1_r <= 1'b0;
      ok_s2_r <= 1'b0;
    end else begin
      cs_s1_r <= spi.cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      ok_s1_r <= hdr_ok_r;
      ok_s2_r <= ok_s1_r;
    end
  end

  // Command report at frame end; frame registers are quiet while select is high
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_op_o    <= 8'h00;
      cmd_addr_o  <= 19'h00000;
      cmd_cnt_o   <= 9'h000;
      cmd_dual_o  <= 1'b0;
    end else begin
      cmd_valid_o <= 1'b0;
      if (cs_s2_r && !cs_s3_r && ok_s2_r) begin
        cmd_valid_o <= 1'b1;
        cmd_op_o    <= op_r;
        cmd_addr_o  <= addr_r;
        cmd_cnt_o   <= cnt_r;
        cmd_dual_o  <= dual_r;
      end
    end
  end

endmodule

// ==== verif/sfcfe_link_assertions.sv ====
// Link checker for the flash command front end: watches the SPI wires.
// Assumes the link clock is a core-clock register, so each link edge lands on a core edge.
`timescale 1ns/100ps
module sfcfe_link_assertions (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  // One domain is enough; sampling on the core clock sees every link edge
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // Device output: only while selected, launched on falling edges
  chk_oe_select_idle: assert property (cs_n |-> !so_oe)
    else $error("so_oe high while deselected");
  chk_oe_rise_fall: assert property ($rose(so_oe) |-> $fell(sck) && !cs_n)
    else $error("so_oe rose off a falling edge");
  chk_so_change_fall: assert property (so_oe && $past(so_oe) && $changed(so) |-> $fell(sck))
    else $error("so changed off a falling edge");
  chk_oe_quiet_opcode: assert property ($fell(cs_n) |-> !so_oe [*8])
    else $error("so driven during opcode");
  // Host side: bits launched on falling edges, frames spaced
  chk_si_change_fall: assert property (!cs_n && !$fell(cs_n) && $changed(si) |-> $fell(sck))
    else $error("si changed off a falling edge");
  chk_select_gap_held: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("select gap too short");
  chk_sck_high_time: assert property ($rose(sck) && !cs_n |-> sck [*3])
    else $error("link clock high phase short");
  chk_select_before_clk: assert property ($fell(cs_n) |-> $stable(sck) [*2])
    else $error("link clock moved at select");

  cover property ($rose(so_oe));
  cover property ($rose(cs_n) && sck);
  cover property ($fell(so_oe) && cs_n);
endmodule

// ==== verif/tb.sv ====
// Bench: host and device ends on one link; checks host bytes, device reports and wires.
// Assumes the host divides the link clock from the core clock, so one bench clock.
`timescale 1ns/100ps
module tb;
  localparam logic [7:0]  MFR_V  = 8'hC3;  // Arbitrary value
  localparam logic [7:0]  DEV_V  = 8'h4D;  // Arbitrary value
  localparam logic [7:0]  DEV2_V = 8'h71;  // Arbitrary value
  localparam logic [7:0]  ST1_V  = 8'h96;
  localparam logic [7:0]  ST2_V  = 8'h69;
  localparam logic [7:0]  FILL   = 8'h5A;
  localparam logic [23:0] ADR_T  = 24'hABCDE1;

  logic        core_clk, rst, mode3, start, busy, wr_take, rd_valid, cmd_valid, cmd_dual;
  logic [7:0]  op, wr_data, wd_next, rd_data, cmd_op, so_bits;
  logic [23:0] addr;
  logic [2:0]  n_hdr;
  logic [8:0]  n_data, cmd_cnt;
  logic [18:0] cmd_addr;
  logic [31:0] si_bits;
  logic [7:0]  rd_q[$];
  int          fail_count, checked, cycles, wire_n, so_from, rep_n, rep0;

  // Once filled, the array holds a + FILL at address a
  logic [7:0]  rd_op[4]     = '{8'h03, 8'h0B, 8'h48, 8'h03};
  logic [23:0] rd_adr[4]    = '{24'hF7FFFE, 24'h0000F0, 24'hFFFF7E, 24'h87FFFD};
  logic [7:0]  id_op[4]     = '{8'h05, 8'h35, 8'h9F, 8'h90};
  logic [7:0]  id_exp[4][3] = '{'{ST1_V, 8'h00, 8'h00}, '{ST2_V, 8'h00, 8'h00}, '{MFR_V, DEV_V, DEV2_V},
                                '{MFR_V, DEV_V, 8'h00}};
  int          id_n[4]      = '{1, 1, 3, 2};
  logic [7:0]  nd_op[15]    = '{8'h20, 8'h52, 8'hD8, 8'h44, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'h60, 8'hC7, 8'h06,
                                8'h04, 8'h50, 8'hB9, 8'hAB};
  logic [7:0]  in_op[5]     = '{8'h01, 8'h42, 8'hFF, 8'hFF, 8'hFF};
  logic [8:0]  in_n[5]      = '{9'h002, 9'h003, 9'h001, 9'h001, 9'h000};
  logic [7:0]  in_wd[5]     = '{8'h11, 8'h22, 8'hFF, 8'hFE, 8'hFF};
  logic [7:0]  rf_op[3]     = '{8'h77, 8'h03, 8'h02};
  logic [2:0]  rf_hdr[3]    = '{3'h3, 3'h2, 3'h0};

  sfcfe_spi_if spi_link ();
  sfcfe_host sfcfe_host_inst (.core_clk_i(core_clk), .rst_i(rst), .mode3_i(mode3), .start_i(start), .op_i(op),
    .addr_i(addr), .n_hdr_i(n_hdr), .n_data_i(n_data), .wr_data_i(wr_data), .busy_o(busy), .wr_take_o(wr_take),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .spi(spi_link.host));
  sfcfe_dev #(.STAT1(ST1_V), .STAT2(ST2_V), .MFR_ID(MFR_V), .DEV_ID(DEV_V), .DEV_ID2(DEV2_V)) sfcfe_dev_inst (
    .core_clk_i(core_clk), .rst_i(rst), .spi(spi_link.dev), .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op),
    .cmd_addr_o(cmd_addr), .cmd_cnt_o(cmd_cnt), .cmd_dual_o(cmd_dual));
  sfcfe_link_assertions sfcfe_link_assertions_inst (.core_clk_i(core_clk), .rst_i(rst), .cs_n(spi_link.cs_n),
    .sck(spi_link.sck), .si(spi_link.si), .so(spi_link.so), .so_oe(spi_link.so_oe));

  always #50 core_clk = ~core_clk;

  // Collect host bytes and reports; next write byte is one above the last
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (cmd_valid === 1'b1) rep_n <= rep_n + 1;
    if (start === 1'b1) wr_data <= wd_next;
    else if (wr_take === 1'b1) wr_data <= wr_data + 8'h01;
  end

  // Wire view at sampling edges: first 32 bits in, first data byte out
  always @(posedge spi_link.sck or posedge spi_link.cs_n) begin
    if (spi_link.cs_n) begin
      wire_n <= 0;
    end else begin
      wire_n <= wire_n + 1;
      if (wire_n < 32) si_bits <= {si_bits[30:0], spi_link.si};
      if (wire_n >= so_from && wire_n < so_from + 8) so_bits <= {so_bits[6:0], spi_link.so_line};
    end
  end

  // Whole plan needs about 19000 cycles; a hang is cut short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      $display("Error run length: expected below 40000, seen %0d", cycles);
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One framed command through the host; returns once it is idle again
  task automatic run(input logic m, input logic [7:0] o, input logic [23:0] a, input logic [2:0] h,
                     input logic [8:0] n, input logic [7:0] wd);
    int k;
    rd_q.delete();
    rep0 = rep_n;
    so_from = (h + 1) * 8;
    mode3 <= m;
    op <= o;
    addr <= a;
    n_hdr <= h;
    n_data <= n;
    wd_next <= wd;
    @(posedge core_clk);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (busy !== 1'b0 && k < 20000);
    repeat (3) @(posedge core_clk);
  endtask

  task automatic expect_rep(input logic e, input logic [7:0] o, input logic [8:0] c, input logic d);
    chk("report count", e, rep_n - rep0);
    if (e) begin
      chk("opcode", o, cmd_op);
      chk("byte count", c, cmd_cnt);
      chk("dual reset", d, cmd_dual);
    end
  endtask

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    mode3 = 1'b0;
    start = 1'b0;
    op = 8'h00;
    addr = 24'h000000;
    n_hdr = 3'h0;
    n_data = 9'h000;
    wd_next = 8'h00;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    // Fill the whole page, full 256-byte count
    run(1'b0, 8'h02, 24'hE7FF00, 3'h3, 9'h100, FILL);
    expect_rep(1'b1, 8'h02, 9'h100, 1'b0);
    chk("opcode and address on si", {8'h02, 24'hE7FF00}, si_bits);
    $display("Test fill done");
    // Array reads, both modes, two of them across the top of the array
    for (int i = 0; i < 4; i++) begin
      run(i[0], rd_op[i], rd_adr[i], (rd_op[i] == 8'h03) ? 3'h3 : 3'h4, 9'h004, 8'h00);
      expect_rep(1'b1, rd_op[i], 9'h000, 1'b0);
      chk("read length", 4, rd_q.size());
      chk("read end address", 19'(rd_adr[i][18:0] + 19'h00004), cmd_addr);
      for (int k = 0; k < 4; k++) chk("read byte", 8'(rd_adr[i][7:0] + k + FILL), rd_q[k]);
      chk("first byte on so", 8'(rd_adr[i][7:0] + FILL), so_bits);
      chk("link clock idle", mode3, spi_link.sck);
      chk("so released", 1'b0, spi_link.so_oe);
    end
    $display("Test reads done");
    // Status and identification answers
    for (int i = 0; i < 4; i++) begin
      run(i[0], id_op[i], 24'h000000, (id_op[i] == 8'h90) ? 3'h3 : 3'h0, 9'h003, 8'h00);
      expect_rep(1'b1, id_op[i], 9'h000, 1'b0);
      for (int k = 0; k < id_n[i]; k++) chk("answer byte", id_exp[i][k], rd_q[k]);
    end
    $display("Test answers done");
    // Commands without data; address commands drop the top five bits
    for (int i = 0; i < 15; i++) begin
      run(1'b0, nd_op[i], ADR_T, (i < 8) ? 3'h3 : 3'h0, 9'h000, 8'h00);
      expect_rep(1'b1, nd_op[i], 9'h000, 1'b0);
      if (i < 8) chk("address", ADR_T[18:0], cmd_addr);
    end
    $display("Test plain commands done");
    // Commands that take data, and the two read-mode resets
    for (int i = 0; i < 5; i++) begin
      run(1'b1, in_op[i], ADR_T, (in_op[i] == 8'h42) ? 3'h3 : 3'h0, in_n[i], in_wd[i]);
      expect_rep(1'b1, in_op[i], in_n[i], i == 2);
    end
    $display("Test data commands done");
    // Unknown opcode and short headers; trailing bytes mimic a valid opcode
    for (int i = 0; i < 3; i++) begin
      run(1'b0, rf_op[i], 24'h060000, rf_hdr[i], (i == 1) ? 9'h000 : 9'h002, 8'h06);
      expect_rep(1'b0, 8'h00, 9'h000, 1'b0);
    end
    run(1'b0, 8'h05, 24'h000000, 3'h0, 9'h001, 8'h00);
    expect_rep(1'b1, 8'h05, 9'h000, 1'b0);
    $display("Test refusals done");
    give_verdict();
  end
endmodule
